// >>> shared/dmarnb_map.vh
// register map, field positions, reset values and mode codes of the engine
`ifndef DMARNB_MAP_VH
`define DMARNB_MAP_VH

// register byte offsets
`define DMARNB_OFF_ADDR_A   6'h00
`define DMARNB_OFF_IO_LOW   6'h04
`define DMARNB_OFF_COUNT_A  6'h08
`define DMARNB_OFF_ADDR_B   6'h0c
`define DMARNB_OFF_BLK_CNT  6'h10
`define DMARNB_OFF_A_CTRL   6'h14
`define DMARNB_OFF_B_CTRL   6'h18
`define DMARNB_OFF_STATUS   6'h1c

// a_control_register fields
`define DMARNB_A_ENABLE     7
`define DMARNB_A_SIZE       6
`define DMARNB_A_SRC_DIR    5
`define DMARNB_A_SRC_STEP   4
`define DMARNB_A_IRQ_EN     3
`define DMARNB_A_FINISHED   8

// b_control_register fields
`define DMARNB_B_PAIR_EN    7
`define DMARNB_B_AREA_SRC   6
`define DMARNB_B_DST_DIR    5
`define DMARNB_B_DST_STEP   4

// select codes
`define DMARNB_SEL_NORMAL   3'h6
`define DMARNB_SEL_BLOCK    3'h7
`define DMARNB_SEL_TXE      3'h4
`define DMARNB_SEL_RXF      3'h5
`define DMARNB_SEL_EXT_FALL 3'h6
`define DMARNB_SEL_EXT_LOW  3'h7
`define DMARNB_NSEL_BURST   3'h1
`define DMARNB_NSEL_FALL    3'h2
`define DMARNB_NSEL_LOW     3'h3
`define DMARNB_BSEL_FALL    3'h4

// reset values
`define DMARNB_RST_ADDR     24'h000000
`define DMARNB_RST_BYTE     8'h00
`define DMARNB_RST_HALF     16'h0000

`endif

// >>> rtl/dmarnb_sync.v
// two-flop synchroniser with falling-edge detect for request pins
`timescale 1ns/1ps
module dmarnb_sync #(
    parameter W = 1
) (
    // clocking
    input  wire         mclk,
    input  wire         srst,
    input  wire         ce,
    // pins and results
    input  wire [W-1:0] pin_in,
    output wire [W-1:0] lvl_out,
    output wire [W-1:0] fall_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            reg s1_q;
            reg s2_q;
            reg s3_q;
            // idle level of an active-low pin is high
            always @(posedge mclk)
            begin
                if (srst)
                begin
                    s1_q <= 1'b1;
                    s2_q <= 1'b1;
                    s3_q <= 1'b1;
                end
                else if (ce)
                begin
                    s1_q <= pin_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end
            // edge taken only past the second flop
            assign lvl_out[i]  = s2_q;
            assign fall_out[i] = s3_q & ~s2_q & ce;
        end
    endgenerate
endmodule

// >>> rtl/dmarnb_engine.v
// repeat, normal and block transfer engine with ahb-lite registers
// What this block does
// - repeat: one unit per request, restore address and count after run
// - repeat: serial receive-full copies io to memory, else memory to io
// - repeat: live count byte drops per transfer, reloads from initial byte
// - repeat wrap: address minus signed step times initial count
// - repeat runs until enable cleared, no completion interrupt, resumes
// - io address is all-ones upper 16 bits over 8-bit low, never steps
// - repeat count is 8 bits; zero means 256 transfers
// - repeat triggers: timer 0-3, serial tx-empty, rx-full, external
// - normal: pair source and destination 24-bit, each steps or holds
// - normal: 16-bit count drops; at zero clear enable, stop, interrupt
// - normal: auto request from setup alone, or external request
// - cycle-steal frees bus per transfer; burst holds unless preempted
// - a select bits 1,1,0 choose normal mode on the pair
// - block: burst one block per request, size byte reloads at zero
// - b control area bit picks block area; 0 means destination
// - block area address returns to start at each block end
// - block counter drops per block; waits, or at zero ends
// - block triggers: timer 0-3 and external request only
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "dmarnb_map.vh"
module dmarnb_engine (
    // clocking
    input  wire        mclk,
    input  wire        srst,
    input  wire        ce,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // request sources
    input  wire [3:0]  timer_trig,
    input  wire        ser_txe,
    input  wire        ser_rxf,
    input  wire        dreq_n,
    // system bus master
    output wire        bus_req,
    input  wire        bus_grant,
    input  wire        hp_bus_req,
    output reg  [23:0] mem_addr,
    output wire        mem_rd,
    output wire        mem_wr,
    output reg         mem_word,
    output reg  [15:0] mem_wdata,
    input  wire [15:0] mem_rdata,
    input  wire        mem_ack,
    // completion
    output reg         done_irq
);
    localparam S_IDLE = 3'h0;
    localparam S_REQ  = 3'h1;
    localparam S_RD   = 3'h2;
    localparam S_WR   = 3'h3;
    localparam S_UPD  = 3'h4;

    reg [23:0] addr_a_q;
    reg [7:0]  io_low_q;
    reg [15:0] cnt_a_q;
    reg [23:0] addr_b_q;
    reg [15:0] blk_q;
    reg [7:0]  actl_q;
    reg        fin_q;
    reg [7:0]  bctl_q;
    reg [2:0]  state_q;
    reg        pend_q;
    reg        in_blk_q;
    reg        rx_dir_q;
    reg        wr_pend_q;
    reg [5:0]  wr_addr_q;

    wire       ext_lvl;
    wire       ext_fall;
    dmarnb_sync #(.W(1)) u_sync (
        .mclk     (mclk),
        .srst     (srst),
        .ce       (ce),
        .pin_in   (dreq_n),
        .lvl_out  (ext_lvl),
        .fall_out (ext_fall)
    );

    // mode decode from the select fields
    wire [2:0] asel   = actl_q[2:0];
    wire [2:0] bsel   = bctl_q[2:0];
    wire       pair   = bctl_q[`DMARNB_B_PAIR_EN];
    wire       m_rep  = ~pair;
    wire       m_norm = pair & (asel == `DMARNB_SEL_NORMAL);
    wire       m_blk  = pair & (asel == `DMARNB_SEL_BLOCK);
    wire       en     = actl_q[`DMARNB_A_ENABLE];
    wire       sz     = actl_q[`DMARNB_A_SIZE];

    // edge-type trigger events, latched as pending
    reg trig_ev;
    always @*
    begin
        trig_ev = 1'b0;
        if (m_rep)
        begin
            case (asel)
                3'h0, 3'h1, 3'h2, 3'h3: trig_ev = timer_trig[asel[1:0]];
                `DMARNB_SEL_TXE:        trig_ev = ser_txe;
                `DMARNB_SEL_RXF:        trig_ev = ser_rxf;
                `DMARNB_SEL_EXT_FALL:   trig_ev = ext_fall;
                default:                trig_ev = 1'b0;
            endcase
        end
        else if (m_norm)
            trig_ev = (bsel == `DMARNB_NSEL_FALL) & ext_fall;
        else if (m_blk)
        begin
            case (bsel)
                3'h0, 3'h1, 3'h2, 3'h3: trig_ev = timer_trig[bsel[1:0]];
                `DMARNB_BSEL_FALL:      trig_ev = ext_fall;
                default:                trig_ev = 1'b0;
            endcase
        end
    end

    // level and auto requests need no latch
    wire auto_rq = m_norm & (bsel[2:1] == 2'b00);
    wire low_rq  = ~ext_lvl & ((m_rep & asel == `DMARNB_SEL_EXT_LOW) |
                   (m_norm & bsel == `DMARNB_NSEL_LOW));
    wire run_rq  = en & (m_rep | m_norm | m_blk) &
                   (pend_q | auto_rq | low_rq | (m_blk & in_blk_q));
    wire take    = (state_q == S_REQ) & bus_grant;
    wire new_unit = take & ~(m_blk & in_blk_q);

    // address stepping by size and direction
    function [23:0] step_a;
        input [23:0] a;
        input        dir;
        input        wsz;
        begin
            if (dir)
                step_a = a - {22'h000000, wsz, ~wsz};
            else
                step_a = a + {22'h000000, wsz, ~wsz};
        end
    endfunction

    // undo a whole run: count zero stands for 256
    function [23:0] unwind;
        input [23:0] a;
        input        dir;
        input        wsz;
        input [7:0]  init;
        reg   [23:0] span;
        begin
            span = wsz ? {14'h0000, (init == 8'h00), init, 1'b0}
                       : {15'h0000, (init == 8'h00), init};
            unwind = dir ? a + span : a - span;
        end
    endfunction

    // repeat direction and fixed io address
    wire [23:0] io_addr = {16'hffff, io_low_q};
    // the unit being taken decides its own direction, not the last one
    wire        rx_now  = new_unit ? (asel == `DMARNB_SEL_RXF) : rx_dir_q;
    wire        to_mem  = m_rep & rx_now;
    wire [23:0] src     = m_rep ? (to_mem ? io_addr : addr_a_q) : addr_a_q;
    wire [23:0] dst     = m_rep ? (to_mem ? addr_a_q : io_addr) : addr_b_q;

    // next values for addresses and counters after one unit
    wire        sdir   = m_rep ? actl_q[`DMARNB_A_SRC_DIR]
                               : actl_q[`DMARNB_A_SRC_DIR];
    wire        sstep  = m_rep | actl_q[`DMARNB_A_SRC_STEP];
    wire        ddir   = bctl_q[`DMARNB_B_DST_DIR];
    wire        dstep  = bctl_q[`DMARNB_B_DST_STEP];
    wire [23:0] a_stp  = sstep ? step_a(addr_a_q, sdir, sz) : addr_a_q;
    wire [23:0] b_stp  = dstep ? step_a(addr_b_q, ddir, sz) : addr_b_q;
    wire [7:0]  hi_nx  = cnt_a_q[15:8] - 8'h01;
    wire [15:0] cnt_nx = cnt_a_q - 16'h0001;
    wire [15:0] blk_nx = blk_q - 16'h0001;
    wire        hi_end = (hi_nx == 8'h00);
    wire        area_s = bctl_q[`DMARNB_B_AREA_SRC];
    wire        burst_go = (m_norm & bsel == `DMARNB_NSEL_BURST &
                           cnt_nx != 16'h0000) |
                           (m_blk & ~hi_end);
    wire        nrm_end = m_norm & (cnt_nx == 16'h0000);
    wire        blk_end = m_blk & hi_end & (blk_nx == 16'h0000);

    // transfer sequencer
    always @(posedge mclk)
    begin
        if (srst)
            state_q <= S_IDLE;
        else if (ce)
        begin
            case (state_q)
                S_IDLE:
                    if (run_rq)
                        state_q <= S_REQ;
                S_REQ:
                    if (bus_grant)
                        state_q <= S_RD;
                S_RD:
                    if (mem_ack)
                        state_q <= S_WR;
                S_WR:
                    if (mem_ack)
                        state_q <= S_UPD;
                S_UPD:
                    // preemption drops the bus between units
                    if (burst_go & ~hp_bus_req & en)
                        state_q <= S_REQ;
                    else
                        state_q <= S_IDLE;
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    // bus right held from request through update
    assign bus_req = (state_q != S_IDLE);
    assign mem_rd  = (state_q == S_RD);
    assign mem_wr  = (state_q == S_WR);

    // bus address and data registers
    always @(posedge mclk)
    begin
        if (srst)
        begin
            mem_addr  <= `DMARNB_RST_ADDR;
            mem_word  <= 1'b0;
            mem_wdata <= `DMARNB_RST_HALF;
            rx_dir_q  <= 1'b0;
        end
        else if (ce)
        begin
            if (take)
            begin
                mem_addr <= src;
                mem_word <= sz;
            end
            if (new_unit)
                rx_dir_q <= (asel == `DMARNB_SEL_RXF);
            if (mem_rd & mem_ack)
            begin
                mem_addr  <= dst;
                mem_wdata <= mem_rdata;
            end
        end
    end

    // pending edge request: an event wins over its own consumption
    always @(posedge mclk)
    begin
        if (srst)
            pend_q <= 1'b0;
        else if (ce)
            pend_q <= (pend_q & ~new_unit) | trig_ev;
    end

    // ahb-lite address phase capture
    wire ahb_go = hsel & htrans[1] & hready;
    wire ahb_wr = ahb_go & hwrite;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // read mux, unmapped reads as zero
    reg [31:0] rd_mux;
    always @*
    begin
        case (haddr[7:0])
            {2'b00, `DMARNB_OFF_ADDR_A}:  rd_mux = {8'h00, addr_a_q};
            {2'b00, `DMARNB_OFF_IO_LOW}:  rd_mux = {24'h000000, io_low_q};
            {2'b00, `DMARNB_OFF_COUNT_A}: rd_mux = {16'h0000, cnt_a_q};
            {2'b00, `DMARNB_OFF_ADDR_B}:  rd_mux = {8'h00, addr_b_q};
            {2'b00, `DMARNB_OFF_BLK_CNT}: rd_mux = {16'h0000, blk_q};
            {2'b00, `DMARNB_OFF_A_CTRL}:  rd_mux = {23'h000000, fin_q, actl_q};
            {2'b00, `DMARNB_OFF_B_CTRL}:  rd_mux = {24'h000000, bctl_q};
            {2'b00, `DMARNB_OFF_STATUS}:  rd_mux = {27'h0000000, state_q,
                                                   in_blk_q, pend_q};
            default:                      rd_mux = 32'h00000000;
        endcase
    end

    // read data latched at the address phase, write held to data phase
    always @(posedge mclk)
    begin
        if (srst)
        begin
            hrdata    <= 32'h00000000;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 6'h00;
        end
        else if (ce)
        begin
            wr_pend_q <= ahb_wr & (haddr[31:6] == 26'h0000000);
            if (ahb_wr)
                wr_addr_q <= haddr[5:0];
            if (ahb_go & ~hwrite)
                hrdata <= (haddr[31:6] == 26'h0000000) ? rd_mux
                                                       : 32'h00000000;
        end
    end

    // out-of-range writes were dropped at their address phase
    wire wr_hit = wr_pend_q;
    wire upd    = (state_q == S_UPD);

    // software register writes win over engine updates of the same word
    always @(posedge mclk)
    begin
        if (srst)
        begin
            addr_a_q <= `DMARNB_RST_ADDR;
            io_low_q <= `DMARNB_RST_BYTE;
            cnt_a_q  <= `DMARNB_RST_HALF;
            addr_b_q <= `DMARNB_RST_ADDR;
            blk_q    <= `DMARNB_RST_HALF;
            actl_q   <= `DMARNB_RST_BYTE;
            bctl_q   <= `DMARNB_RST_BYTE;
            in_blk_q <= 1'b0;
        end
        else if (ce)
        begin
            if (new_unit & m_blk)
                in_blk_q <= 1'b1;
            if (upd & m_rep)
            begin
                // count and address restore, channel keeps running
                if (hi_end)
                begin
                    cnt_a_q[15:8] <= cnt_a_q[7:0];
                    addr_a_q <= unwind(a_stp, sdir, sz,
                                       cnt_a_q[7:0]);
                end
                else
                begin
                    cnt_a_q[15:8] <= hi_nx;
                    addr_a_q      <= a_stp;
                end
            end
            if (upd & m_norm)
            begin
                addr_a_q <= a_stp;
                addr_b_q <= b_stp;
                cnt_a_q  <= cnt_nx;
                if (nrm_end)
                    actl_q[`DMARNB_A_ENABLE] <= 1'b0;
            end
            if (upd & m_blk)
            begin
                addr_a_q <= a_stp;
                addr_b_q <= b_stp;
                cnt_a_q[15:8] <= hi_nx;
                if (hi_end)
                begin
                    cnt_a_q[15:8] <= cnt_a_q[7:0];
                    blk_q    <= blk_nx;
                    in_blk_q <= 1'b0;
                    if (area_s & sstep)
                        addr_a_q <= unwind(a_stp, sdir, sz,
                                           cnt_a_q[7:0]);
                    if (~area_s & dstep)
                        addr_b_q <= unwind(b_stp, ddir, sz,
                                           cnt_a_q[7:0]);
                    if (blk_nx == 16'h0000)
                        actl_q[`DMARNB_A_ENABLE] <= 1'b0;
                end
            end
            if (wr_hit)
            begin
                case (wr_addr_q)
                    `DMARNB_OFF_ADDR_A:  addr_a_q <= hwdata[23:0];
                    `DMARNB_OFF_IO_LOW:  io_low_q <= hwdata[7:0];
                    `DMARNB_OFF_COUNT_A: cnt_a_q  <= hwdata[15:0];
                    `DMARNB_OFF_ADDR_B:  addr_b_q <= hwdata[23:0];
                    `DMARNB_OFF_BLK_CNT: blk_q    <= hwdata[15:0];
                    // clearing enable just parks the state; set resumes
                    `DMARNB_OFF_A_CTRL:  actl_q   <= hwdata[7:0];
                    `DMARNB_OFF_B_CTRL:  bctl_q   <= hwdata[7:0];
                    default:             io_low_q <= io_low_q;
                endcase
            end
        end
    end

    // finished flag: completion set beats a software clear
    wire fin_set = upd & (nrm_end | blk_end);
    wire fin_clr = wr_hit & (wr_addr_q == `DMARNB_OFF_A_CTRL) &
                   ~hwdata[`DMARNB_A_FINISHED];
    always @(posedge mclk)
    begin
        if (srst)
        begin
            fin_q    <= 1'b0;
            done_irq <= 1'b0;
        end
        else if (ce)
        begin
            fin_q    <= fin_set | (fin_q & ~fin_clr);
            done_irq <= fin_q & actl_q[`DMARNB_A_IRQ_EN];
        end
    end
endmodule

// >>> verif/dmarnb_engine_assertions.sv
// port-level checks of the transfer engine, bound to the engine
`timescale 1ns/1ps
module dmarnb_engine_chk (
    // clocking
    input wire        mclk,
    input wire        srst,
    // transfer side
    input wire        bus_req,
    input wire        bus_grant,
    input wire [23:0] mem_addr,
    input wire        mem_rd,
    input wire        mem_wr,
    input wire [15:0] mem_wdata,
    input wire [15:0] mem_rdata,
    input wire        mem_ack,
    // completion
    input wire        done_irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    // a read holds its address until the far side acknowledges
    a_rd_holds_addr: assert property (
        mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
        else $error("read dropped or moved before ack");
    // the write carries the unit just read
    a_wr_copies_rd: assert property (
        mem_rd && mem_ack |=> mem_wr && mem_wdata == $past(mem_rdata))
        else $error("write does not follow read with its data");
    a_wr_holds_data: assert property (
        mem_wr && !mem_ack |=> mem_wr && $stable(mem_wdata) &&
            $stable(mem_addr))
        else $error("write changed before ack");
    a_no_rd_wr: assert property (!(mem_rd && mem_wr))
        else $error("read and write at once");
    // one update cycle with no access closes every unit
    a_wr_ends_unit: assert property (
        mem_wr && mem_ack |=> !mem_rd && !mem_wr)
        else $error("no update cycle after a unit");
    a_access_owns_bus: assert property (
        mem_rd || mem_wr |-> bus_req && bus_grant)
        else $error("access without owning the bus");
    a_rd_after_grant: assert property (
        $rose(mem_rd) |-> $past(bus_grant) && $past(bus_req))
        else $error("read started without grant");
    a_irq_when_idle: assert property (
        $rose(done_irq) |-> !mem_rd && !mem_wr)
        else $error("completion raised during an access");

    // main scenarios reached
    c_unit: cover property (mem_wr && mem_ack);
    c_done: cover property ($rose(done_irq));
    c_burst: cover property (mem_wr && mem_ack ##1 bus_req ##1 bus_req);
endmodule

bind dmarnb_engine dmarnb_engine_chk i_chk (
    .mclk(mclk), .srst(srst), .bus_req(bus_req), .bus_grant(bus_grant),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .done_irq(done_irq));

// >>> verif/dmarnb_mem_model.sv
// bus arbiter and memory model on the engine's master side
`timescale 1ns/1ps
module dmarnb_mem_model (
    // clocking
    input  wire        mclk,
    input  wire        srst,
    // engine side
    input  wire        bus_req,
    output reg         bus_grant,
    input  wire [23:0] mem_addr,
    input  wire        mem_rd,
    input  wire        mem_wr,
    input  wire [15:0] mem_wdata,
    output reg  [15:0] mem_rdata,
    output reg         mem_ack,
    // bench side
    input  wire [2:0]  slow,
    output reg  [15:0] n_wr,
    output reg  [23:0] last_rd,
    output reg  [23:0] last_wr,
    output reg  [15:0] last_wd
);
    reg [2:0] wait_q;

    // grant one cycle late; ack after slow+1 wait states
    always @(posedge mclk)
    begin
        bus_grant <= bus_req & ~srst;
        // data line never holds a stale value outside reads
        mem_rdata <= mem_rd ? {~mem_addr[7:0], mem_addr[7:0]} : ~mem_rdata;
        if (srst)
        begin
            mem_ack <= 1'b0;
            wait_q <= 3'h0;
            n_wr <= 16'h0000;
            mem_rdata <= 16'h0f0f;
        end
        else if (mem_ack)
        begin
            mem_ack <= 1'b0;
            wait_q <= 3'h0;
            if (mem_rd)
                last_rd <= mem_addr;
            if (mem_wr)
            begin
                last_wr <= mem_addr;
                last_wd <= mem_wdata;
                n_wr <= n_wr + 16'h0001;
            end
        end
        else if (mem_rd || mem_wr)
        begin
            if (wait_q >= slow)
                mem_ack <= 1'b1;
            else
                wait_q <= wait_q + 3'h1;
        end
    end
endmodule

// >>> verif/testbench.sv
// self-checking bench of the repeat, normal and block transfer engine
`timescale 1ns/1ps
module testbench;
    reg         mclk, srst, hsel, hwrite, ser_rxf, dreq_n;
    reg  [31:0] haddr, hwdata;
    reg  [1:0]  htrans;
    reg  [3:0]  timer_trig;
    reg  [2:0]  slow;
    reg  [15:0] nw;
    integer     error_cnt, checks_done, cyc, s;
    wire        hreadyout, hresp, bus_req, bus_grant, mem_rd, mem_wr;
    wire        mem_word, mem_ack, done_irq;
    wire [31:0] hrdata;
    wire [23:0] mem_addr, last_rd, last_wr;
    wire [15:0] mem_wdata, mem_rdata, n_wr, last_wd;

    dmarnb_engine i_dmarnb_engine (.mclk(mclk), .srst(srst), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .timer_trig(timer_trig), .ser_txe(1'b0), .ser_rxf(ser_rxf),
        .dreq_n(dreq_n), .bus_req(bus_req), .bus_grant(bus_grant),
        .hp_bus_req(1'b0), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_word(mem_word), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .done_irq(done_irq));
    dmarnb_mem_model i_dmarnb_mem_model (.mclk(mclk), .srst(srst),
        .bus_req(bus_req), .bus_grant(bus_grant), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .slow(slow),
        .n_wr(n_wr), .last_rd(last_rd), .last_wr(last_wr),
        .last_wd(last_wd));

    always #25 mclk = ~mclk;

    task conclude;
    begin
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    // hang guard, well above the longest run
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            error_cnt = error_cnt + 1;
            conclude;
        end
    end

    task check(input [31:0] seen, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    end
    endtask

    // one single ahb-lite transfer: address phase, then data phase
    task ahb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    begin
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
    end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        reg [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task rdc(input [7:0] a, input [31:0] e);
        reg [31:0] q;
    begin
        ahb(1'b0, a, 32'h0, q);
        check(q, e);
    end
    endtask

    // bit 5 asks for a one-cycle low pulse on the active-low pin
    task pulse(input [5:0] m);
    begin
        @(posedge mclk);
        {dreq_n, ser_rxf, timer_trig} <= m ^ 6'h20;
        @(posedge mclk);
        {dreq_n, ser_rxf, timer_trig} <= 6'h20;
    end
    endtask

    // wait for n units in all, then for the engine to go idle
    task wait_done(input [15:0] n);
        integer i;
        reg [31:0] q;
    begin
        for (i = 0; i < 400 && n_wr !== n; i = i + 1)
            @(posedge mclk);
        check(n_wr, n);
        q = 32'h1;
        for (i = 0; i < 20 && q[4:0] !== 5'h0; i = i + 1)
            ahb(1'b0, 8'h1c, 32'h0, q);
    end
    endtask

    // repeat mode: cnt+1 units prove wrap, reload and restart
    task t_repeat(input [7:0] ctl, input [23:0] b, input [7:0] cnt,
                  input [23:0] st, input [5:0] trig);
        integer k;
        reg [23:0] m;
    begin
        wr(8'h18, 32'h0);
        wr(8'h14, {24'h0, ctl & 8'h7f});
        wr(8'h00, {8'h0, b});
        wr(8'h04, 32'h5a);
        wr(8'h08, {16'h0, cnt, cnt});
        wr(8'h14, {24'h0, ctl});
        for (k = 0; k <= cnt; k = k + 1)
        begin
            m = b + (k % cnt) * st;
            pulse(trig);
            nw = nw + 1;
            wait_done(nw);
            check(last_rd, trig[4] ? 24'hffff5a : m);
            check(last_wr, trig[4] ? m : 24'hffff5a);
            check(last_wd[7:0], last_rd[7:0]);
        end
        m = (cnt == 8'h01) ? b : b + st;
        rdc(8'h00, {8'h0, m});
        rdc(8'h08, {16'h0, (cnt == 8'h01) ? cnt : cnt - 8'h01, cnt});
        check(done_irq, 1'b0);
        // pause and resume carry on from the held address
        wr(8'h14, {24'h0, ctl & 8'h7f});
        wr(8'h14, {24'h0, ctl});
        pulse(trig);
        nw = nw + 1;
        wait_done(nw);
        check(trig[4] ? last_wr : last_rd, m);
        wr(8'h14, 32'h0);
    end
    endtask

    // normal mode armed in the documented order, word units
    task t_normal(input [7:0] bsel);
    begin
        wr(8'h00, 32'h010000);
        wr(8'h0c, 32'h020010);
        wr(8'h08, 32'h0003);
        wr(8'h18, {24'h0, 8'h30 | bsel});
        wr(8'h14, 32'h5e);
        rdc(8'h18, {24'h0, 8'h30 | bsel});
        wr(8'h18, {24'h0, 8'hb0 | bsel});
        rdc(8'h14, 32'h5e);
        wr(8'h14, 32'hde);
        nw = nw + 3;
        wait_done(nw);
        check(last_rd, 24'h010004);
        check(last_wr, 24'h02000c);
        check(mem_word, 1'b1);
        rdc(8'h14, 32'h15e);
        rdc(8'h08, 32'h0);
        check(done_irq, 1'b1);
        wr(8'h14, 32'h5e);
    end
    endtask

    // block mode: two blocks of two bytes, destination is block area
    task t_block;
    begin
        wr(8'h00, 32'h030000);
        wr(8'h0c, 32'h040000);
        wr(8'h08, 32'h0202);
        wr(8'h10, 32'h2);
        wr(8'h18, 32'h10);
        wr(8'h14, 32'h1f);
        wr(8'h18, 32'h90);
        wr(8'h14, 32'h9f);
        pulse(6'h01);
        nw = nw + 2;
        wait_done(nw);
        check(last_wr, 24'h040001);
        rdc(8'h0c, 32'h040000);
        rdc(8'h00, 32'h030002);
        rdc(8'h10, 32'h1);
        rdc(8'h08, 32'h0202);
        pulse(6'h10);
        repeat (20) @(posedge mclk);
        check(n_wr, nw);
        pulse(6'h01);
        nw = nw + 2;
        wait_done(nw);
        check(last_rd, 24'h030003);
        rdc(8'h14, 32'h11f);
        check(done_irq, 1'b1);
        wr(8'h14, 32'h1f);
    end
    endtask

    initial
    begin
        mclk = 0; srst = 1; hsel = 0; hwrite = 0; ser_rxf = 0; dreq_n = 1;
        haddr = 0; hwdata = 0; htrans = 0; timer_trig = 0; slow = 0;
        nw = 0; error_cnt = 0; checks_done = 0; cyc = 0;
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        // all registers clear, unmapped place reads zero
        for (s = 0; s <= 8; s = s + 1)
            rdc(s * 4, 32'h0);
        t_repeat(8'h80, 24'h001000, 8'h02, 24'h000001, 6'h01);
        t_repeat(8'he5, 24'h002000, 8'h03, 24'hfffffe, 6'h10);
        for (s = 1; s < 4; s = s + 1)
            t_repeat(8'h80 | s, 24'h003000, 8'h01, 24'h1, 6'h01 << s);
        t_repeat(8'h86, 24'h004000, 8'h01, 24'h1, 6'h20);
        slow <= 3'h2;
        t_normal(8'h00);
        t_normal(8'h01);
        t_block;
        conclude;
    end
endmodule
